// *** hdl/bsbse_pkg.sv ***
/*
 Shared constants, enumerations and carrier structs of the branch, skip,
 bit and shift execution unit.
 Assumes a single core clock domain and an 8-bit data path.
*/
package bsbse_pkg;
	localparam int W_DATA = 8;
	localparam int W_PC = 16;
	localparam int W_OFS = 7;
	localparam int W_IOA = 5;
	localparam int W_RA = 2;
	localparam int NIB_W = 4;
	// Status register bit positions
	localparam logic [2:0] FLG_C = 3'h0;
	localparam logic [2:0] FLG_Z = 3'h1;
	localparam logic [2:0] FLG_N = 3'h2;
	localparam logic [2:0] FLG_V = 3'h3;
	localparam logic [2:0] FLG_S = 3'h4;
	localparam logic [2:0] FLG_H = 3'h5;
	localparam logic [2:0] FLG_T = 3'h6;
	localparam logic [2:0] FLG_I = 3'h7;
	localparam int BIT_MSB = 7;
	localparam logic [7:0] BIT_ONE = 8'h01;
	localparam logic [7:0] DATA_ZERO = 8'h00;
	// Register port map
	localparam logic [1:0] REG_STATUS = 2'h0;
	localparam logic [1:0] REG_PC_LO = 2'h1;
	localparam logic [1:0] REG_PC_HI = 2'h2;
	localparam logic [1:0] REG_RESULT = 2'h3;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [15:0] PC_RST = 16'h0000;
	// Program counter steps
	localparam logic [15:0] PC_STEP_NEXT = 16'h0001;
	localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
	localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
	// Cycle counts
	localparam logic [1:0] CYC_TAKEN = 2'h2;
	localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
	localparam logic [1:0] CYC_STALL_BASE = 2'h2;
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] CNT_ONE = 2'h1;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_SKIP_IF_IO_BIT_SET = 5'h01,
		OP_BRANCH_STATUS_BIT_SET = 5'h02,
		OP_BRANCH_STATUS_BIT_CLEAR = 5'h03,
		OP_BRANCH_EQUAL = 5'h04,
		OP_BRANCH_NOT_EQUAL = 5'h05,
		OP_BRANCH_CARRY_SET = 5'h06,
		OP_BRANCH_CARRY_CLEAR = 5'h07,
		OP_BRANCH_SAME_OR_HIGHER = 5'h08,
		OP_BRANCH_LOWER = 5'h09,
		OP_BRANCH_MINUS = 5'h0a,
		OP_BRANCH_PLUS = 5'h0b,
		OP_BRANCH_SIGNED_GE = 5'h0c,
		OP_BRANCH_SIGNED_LT = 5'h0d,
		OP_BRANCH_HALFCARRY_SET = 5'h0e,
		OP_BRANCH_HALFCARRY_CLEAR = 5'h0f,
		OP_BRANCH_OVERFLOW_CLEAR = 5'h10,
		OP_BRANCH_IRQ_ENABLED = 5'h11,
		OP_IO_BIT_SET = 5'h12,
		OP_IO_BIT_CLEAR = 5'h13,
		OP_SHIFT_LEFT_LOGICAL = 5'h14,
		OP_SHIFT_RIGHT_LOGICAL = 5'h15,
		OP_SHIFT_RIGHT_ARITH = 5'h16,
		OP_ROTATE_LEFT_CARRY = 5'h17,
		OP_ROTATE_RIGHT_CARRY = 5'h18,
		OP_STATUS_FLAG_SET = 5'h19,
		OP_STATUS_FLAG_CLEAR = 5'h1a,
		OP_STORE_BIT_TO_TRANSFER_FLAG = 5'h1b,
		OP_LOAD_BIT_FROM_TRANSFER_FLAG = 5'h1c,
		OP_SWAP_NIBBLES = 5'h1d
	} bsbse_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STALL = 2'b01,
		ST_IO_RMW = 2'b10
	} bsbse_fsm_t;

	typedef struct packed {
		logic valid;
		bsbse_op_t op;
		logic [2:0] bsel;
		logic [W_OFS-1:0] ofs;
		logic [W_IOA-1:0] io_addr;
		logic [W_DATA-1:0] opnd;
		logic next_two_word;
	} bsbse_cmd_t;

	typedef struct packed {
		logic done;
		logic wr_en;
		logic [W_DATA-1:0] data;
		logic [W_PC-1:0] pc;
		logic [W_DATA-1:0] status;
	} bsbse_res_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [W_IOA-1:0] addr;
		logic [W_DATA-1:0] wdata;
	} bsbse_io_t;
endpackage

// *** hdl/branch_skip_bit_shift_exec.sv ***
/*
 Execution unit for conditional branches, the I/O bit skip, I/O bit set
 and clear, shifts and rotates, status flag transfers and nibble swap.
 Assumes the core hands over one decoded command at a time with the
 working register value, and that the I/O space answers a read in the
 same cycle as its read strobe.
*/
`timescale 1ns/10ps
module branch_skip_bit_shift_exec (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Command
	input wire bsbse_pkg::bsbse_cmd_t i_cmd,
	output logic o_ready,
	// Result
	output bsbse_pkg::bsbse_res_t o_res,
	// I/O space
	output bsbse_pkg::bsbse_io_t o_io,
	input wire logic [7:0] i_io_rdata,
	// Register port
	input wire logic [1:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata
);
	import bsbse_pkg::*;

	typedef struct packed {
		bsbse_fsm_t fsm;
		logic [1:0] cnt;
		bsbse_op_t op;
		logic [W_DATA-1:0] mask;
		logic [W_PC-1:0] pc;
		logic [W_DATA-1:0] status;
		bsbse_res_t res;
		bsbse_io_t io;
		logic [W_DATA-1:0] rdata;
	} bsbse_state_t;

	bsbse_state_t st_ff;
	bsbse_state_t nxt_st;

	function automatic logic branch_cond(bsbse_op_t op, logic [7:0] sr, logic [2:0] b);
		logic c;
		c = 1'b0;
		case (op)
			OP_BRANCH_STATUS_BIT_SET: c = sr[b];
			OP_BRANCH_STATUS_BIT_CLEAR: c = !sr[b];
			OP_BRANCH_EQUAL: c = sr[FLG_Z];
			OP_BRANCH_NOT_EQUAL: c = !sr[FLG_Z];
			OP_BRANCH_CARRY_SET: c = sr[FLG_C];
			OP_BRANCH_CARRY_CLEAR: c = !sr[FLG_C];
			OP_BRANCH_SAME_OR_HIGHER: c = !sr[FLG_C];
			OP_BRANCH_LOWER: c = sr[FLG_C];
			OP_BRANCH_MINUS: c = sr[FLG_N];
			OP_BRANCH_PLUS: c = !sr[FLG_N];
			OP_BRANCH_SIGNED_GE: c = !(sr[FLG_N] ^ sr[FLG_V]);
			OP_BRANCH_SIGNED_LT: c = sr[FLG_N] ^ sr[FLG_V];
			OP_BRANCH_HALFCARRY_SET: c = sr[FLG_H];
			OP_BRANCH_HALFCARRY_CLEAR: c = !sr[FLG_H];
			OP_BRANCH_OVERFLOW_CLEAR: c = !sr[FLG_V];
			OP_BRANCH_IRQ_ENABLED: c = sr[FLG_I];
			default: c = 1'b0;
		endcase
		return c;
	endfunction

	always_comb begin
		logic [W_DATA-1:0] a;
		logic [W_DATA-1:0] r;
		logic [W_DATA-1:0] bmask;
		logic cout;
		logic [W_PC-1:0] disp;
		logic [1:0] cyc;
		a = i_cmd.opnd;
		r = DATA_ZERO;
		cout = 1'b0;
		bmask = BIT_ONE << i_cmd.bsel;
		disp = W_PC'($signed(i_cmd.ofs));
		cyc = CNT_ONE;
		nxt_st = st_ff;
		nxt_st.res.done = 1'b0;
		nxt_st.io.rd = 1'b0;
		nxt_st.io.wr = 1'b0;
		nxt_st.rdata = DATA_ZERO;
		// Register port, read returns the value before any same-cycle write
		if (i_reg_rd) begin
			case (i_reg_addr)
				REG_STATUS: nxt_st.rdata = st_ff.status;
				REG_PC_LO: nxt_st.rdata = st_ff.pc[W_DATA-1:0];
				REG_PC_HI: nxt_st.rdata = st_ff.pc[W_PC-1:W_DATA];
				REG_RESULT: nxt_st.rdata = st_ff.res.data;
				default: nxt_st.rdata = DATA_ZERO;
			endcase
		end
		if (i_reg_wr) begin
			case (i_reg_addr)
				REG_STATUS: nxt_st.status = i_reg_wdata;
				REG_PC_LO: nxt_st.pc[W_DATA-1:0] = i_reg_wdata;
				REG_PC_HI: nxt_st.pc[W_PC-1:W_DATA] = i_reg_wdata;
				default: nxt_st.pc = nxt_st.pc;
			endcase
		end
		case (st_ff.fsm)
			ST_IDLE: begin
				if (i_cmd.valid) begin
					nxt_st.op = i_cmd.op;
					nxt_st.res.wr_en = 1'b0;
					nxt_st.res.data = a;
					nxt_st.pc = nxt_st.pc + PC_STEP_NEXT;
					case (i_cmd.op)
						OP_SKIP_IF_IO_BIT_SET: begin
							if ((a & bmask) != DATA_ZERO) begin
								// Skip over a one or two word instruction
								if (i_cmd.next_two_word) begin
									nxt_st.pc = st_ff.pc + PC_SKIP_TWO;
									cyc = CYC_SKIP_TWO;
								end else begin
									nxt_st.pc = st_ff.pc + PC_SKIP_ONE;
									cyc = CYC_SKIP_ONE;
								end
							end
						end
						OP_BRANCH_STATUS_BIT_SET, OP_BRANCH_STATUS_BIT_CLEAR,
						OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
						OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
						OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_LOWER,
						OP_BRANCH_MINUS, OP_BRANCH_PLUS,
						OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
						OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR,
						OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED: begin
							if (branch_cond(i_cmd.op, nxt_st.status, i_cmd.bsel)) begin
								// Target is PC plus signed offset plus one
								nxt_st.pc = st_ff.pc + disp + PC_STEP_NEXT;
								cyc = CYC_TAKEN;
							end
						end
						OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
							// Read then write back the addressed I/O register
							nxt_st.io.rd = 1'b1;
							nxt_st.io.addr = i_cmd.io_addr;
							nxt_st.mask = bmask;
						end
						OP_SHIFT_LEFT_LOGICAL: begin
							r = {a[BIT_MSB-1:0], 1'b0};
							cout = a[BIT_MSB];
						end
						OP_SHIFT_RIGHT_LOGICAL: begin
							r = {1'b0, a[BIT_MSB:1]};
							cout = a[0];
						end
						OP_SHIFT_RIGHT_ARITH: begin
							r = {a[BIT_MSB], a[BIT_MSB:1]};
							cout = a[0];
						end
						OP_ROTATE_LEFT_CARRY: begin
							r = {a[BIT_MSB-1:0], nxt_st.status[FLG_C]};
							cout = a[BIT_MSB];
						end
						OP_ROTATE_RIGHT_CARRY: begin
							r = {nxt_st.status[FLG_C], a[BIT_MSB:1]};
							cout = a[0];
						end
						OP_STATUS_FLAG_SET: nxt_st.status[i_cmd.bsel] = 1'b1;
						OP_STATUS_FLAG_CLEAR: nxt_st.status[i_cmd.bsel] = 1'b0;
						OP_STORE_BIT_TO_TRANSFER_FLAG: nxt_st.status[FLG_T] = a[i_cmd.bsel];
						OP_LOAD_BIT_FROM_TRANSFER_FLAG: begin
							nxt_st.res.data[i_cmd.bsel] = nxt_st.status[FLG_T];
							nxt_st.res.wr_en = 1'b1;
						end
						OP_SWAP_NIBBLES: begin
							nxt_st.res.data = {a[NIB_W-1:0], a[W_DATA-1:NIB_W]};
							nxt_st.res.wr_en = 1'b1;
						end
						default: nxt_st.res.wr_en = 1'b0;
					endcase
					// Shift and rotate result with Z C N V update
					if (i_cmd.op inside {OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
						OP_SHIFT_RIGHT_ARITH, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY}) begin
						nxt_st.res.data = r;
						nxt_st.res.wr_en = 1'b1;
						nxt_st.status[FLG_C] = cout;
						nxt_st.status[FLG_Z] = (r == DATA_ZERO);
						nxt_st.status[FLG_N] = r[BIT_MSB];
						nxt_st.status[FLG_V] = r[BIT_MSB] ^ cout;
					end
					if (i_cmd.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR}) begin
						nxt_st.pc = st_ff.pc;
						nxt_st.fsm = ST_IO_RMW;
					end else if (cyc == CNT_ONE) begin
						// Not-taken branch or single-cycle op
						nxt_st.res.done = 1'b1;
					end else begin
						nxt_st.fsm = ST_STALL;
						nxt_st.cnt = cyc - CYC_STALL_BASE;
					end
				end
			end
			ST_STALL: begin
				if (st_ff.cnt == CNT_ZERO) begin
					nxt_st.res.done = 1'b1;
					nxt_st.fsm = ST_IDLE;
				end else begin
					nxt_st.cnt = st_ff.cnt - CNT_ONE;
				end
			end
			ST_IO_RMW: begin
				nxt_st.io.wr = 1'b1;
				if (st_ff.op == OP_IO_BIT_SET) begin
					nxt_st.io.wdata = i_io_rdata | st_ff.mask;
				end else begin
					nxt_st.io.wdata = i_io_rdata & ~st_ff.mask;
				end
				nxt_st.res.data = nxt_st.io.wdata;
				nxt_st.pc = nxt_st.pc + PC_STEP_NEXT;
				nxt_st.res.done = 1'b1;
				nxt_st.fsm = ST_IDLE;
			end
			default: nxt_st.fsm = ST_IDLE;
		endcase
		nxt_st.res.pc = nxt_st.pc;
		nxt_st.res.status = nxt_st.status;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= '{fsm: ST_IDLE, cnt: CNT_ZERO, op: OP_NOP, mask: DATA_ZERO,
				pc: PC_RST, status: STATUS_RST,
				res: '{done: 1'b0, wr_en: 1'b0, data: DATA_ZERO, pc: PC_RST, status: STATUS_RST},
				io: '{rd: 1'b0, wr: 1'b0, addr: '0, wdata: DATA_ZERO},
				rdata: DATA_ZERO};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign o_ready = (st_ff.fsm == ST_IDLE);
	assign o_res = st_ff.res;
	assign o_io = st_ff.io;
	assign o_reg_rdata = st_ff.rdata;
endmodule // branch_skip_bit_shift_exec

// *** bench/bsbse_io_model.sv ***
/*
 I/O register space seen by the execution unit in the bench.
 Assumes the unit samples read data in the cycle of its read strobe.
*/
`timescale 1ns/10ps
module bsbse_io_model (
	// Clock
	input wire logic i_clk_sys,
	// I/O access
	input wire bsbse_pkg::bsbse_io_t i_io,
	output logic [7:0] o_rdata
);
	import bsbse_pkg::*;
	logic [7:0] mem [32];
	initial begin
		for (int i = 0; i < 32; i++) mem[i] = 8'h5a ^ 8'(i);
	end
	// Inverted value outside read cycles so stale data never looks valid
	assign o_rdata = i_io.rd ? mem[i_io.addr] : ~mem[i_io.addr];
	always @(posedge i_clk_sys) begin
		if (i_io.wr) mem[i_io.addr] <= i_io.wdata;
	end
endmodule // bsbse_io_model

// *** bench/branch_skip_bit_shift_exec_props.sv ***
/*
 Port checks of the execution unit, bound to its top module.
 Assumes one clock domain with asynchronous active-low reset.
*/
`timescale 1ns/10ps
module bsbse_props (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Watched ports
	input wire bsbse_pkg::bsbse_cmd_t i_cmd,
	input wire logic o_ready,
	input wire bsbse_pkg::bsbse_res_t o_res,
	input wire bsbse_pkg::bsbse_io_t o_io,
	input wire logic [7:0] i_io_rdata,
	input wire logic i_reg_wr
);
	import bsbse_pkg::*;
	logic tk;
	bsbse_op_t op;
	logic [7:0] x;
	assign tk = i_cmd.valid && o_ready && !i_reg_wr;
	assign op = i_cmd.op;
	assign x = i_cmd.opnd;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	AST_SHIFT_LEFT: assert property (tk && op == OP_SHIFT_LEFT_LOGICAL |=>
		o_res.done && o_res.data == {$past(x[6:0]), 1'b0}) else $error("bad left shift");
	AST_ROTATE_RIGHT: assert property (tk && op == OP_ROTATE_RIGHT_CARRY |=>
		o_res.status[FLG_C] == $past(x[0]) &&
		o_res.data == {$past(o_res.status[FLG_C]), $past(x[7:1])}) else $error("bad rotate");
	AST_SWAP: assert property (tk && op == OP_SWAP_NIBBLES |=>
		o_res.data == {$past(x[3:0]), $past(x[7:4])} && $stable(o_res.status))
		else $error("bad swap");
	AST_BIT_STORE: assert property (tk && op == OP_STORE_BIT_TO_TRANSFER_FLAG |=>
		o_res.status[FLG_T] == $past(x[i_cmd.bsel])) else $error("bad bit store");
	AST_BEQ: assert property (tk && op == OP_BRANCH_EQUAL && o_res.status[FLG_Z] |=>
		!o_res.done && !o_ready ##1 o_res.done && o_res.pc == $past(o_res.pc, 2) +
		{{9{$past(i_cmd.ofs[6], 2)}}, $past(i_cmd.ofs, 2)} + PC_STEP_NEXT)
		else $error("bad taken branch");
	AST_BNE: assert property (tk && op == OP_BRANCH_NOT_EQUAL && o_res.status[FLG_Z] |=>
		o_res.done && o_res.pc == $past(o_res.pc) + PC_STEP_NEXT) else $error("bad fall through");
	AST_SKIP: assert property (tk && op == OP_SKIP_IF_IO_BIT_SET && x[i_cmd.bsel] &&
		i_cmd.next_two_word |=> !o_res.done [*2] ##1 o_res.done &&
		o_res.pc == $past(o_res.pc, 3) + PC_SKIP_TWO) else $error("bad skip");
	AST_IO_CLEAR: assert property (tk && op == OP_IO_BIT_CLEAR |=>
		o_io.rd && o_io.addr == $past(i_cmd.io_addr) ##1 o_io.wr && o_res.done &&
		o_io.wdata == ($past(i_io_rdata) & ~(BIT_ONE << $past(i_cmd.bsel, 2))))
		else $error("bad io clear");
endmodule // bsbse_props
bind branch_skip_bit_shift_exec bsbse_props u_props (.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n), .i_cmd(i_cmd), .o_ready(o_ready), .o_res(o_res), .o_io(o_io),
	.i_io_rdata(i_io_rdata), .i_reg_wr(i_reg_wr));

// *** bench/branch_skip_bit_shift_exec_tb.sv ***
/*
 Self-checking bench of the execution unit.
 Assumes the I/O model answers reads in the cycle of the read strobe.
*/
`timescale 1ns/10ps
module branch_skip_bit_shift_exec_tb;
	import bsbse_pkg::*;
	logic i_clk_sys;
	logic i_rst_n;
	logic o_ready;
	logic i_reg_wr;
	logic i_reg_rd;
	bsbse_cmd_t i_cmd;
	bsbse_res_t o_res;
	bsbse_io_t o_io;
	logic [7:0] i_io_rdata;
	logic [7:0] i_reg_wdata;
	logic [7:0] o_reg_rdata;
	logic [7:0] v;
	logic [1:0] i_reg_addr;
	logic [15:0] pc_e;
	logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h2a, 8'h95};
	logic [7:0] xs [4] = '{8'h81, 8'h01, 8'h40, 8'hc0};
	int fail_count;
	int comparisons;
	branch_skip_bit_shift_exec DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_cmd(i_cmd), .o_ready(o_ready), .o_res(o_res), .o_io(o_io),
		.i_io_rdata(i_io_rdata), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
	bsbse_io_model u_io (.i_clk_sys(i_clk_sys), .i_io(o_io), .o_rdata(i_io_rdata));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		@(negedge i_clk_sys);
		v = o_reg_rdata;
	endtask
	task automatic issue(input bsbse_op_t op, input logic [2:0] b, input logic [7:0] x,
		input logic [7:0] s);
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] m;
		logic [6:0] o;
		logic [15:0] p;
		logic t;
		logic io;
		logic w;
		int n;
		int k;
		o = {b, 4'h9};
		d = x;
		e = s;
		t = 1'b0;
		p = pc_e + 16'h0001;
		m = u_io.mem[x[4:0]];
		io = op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR;
		w = (op >= OP_SHIFT_LEFT_LOGICAL && op <= OP_ROTATE_RIGHT_CARRY) ||
			op == OP_LOAD_BIT_FROM_TRANSFER_FLAG || op == OP_SWAP_NIBBLES;
		n = io ? 2 : 1;
		case (op)
			OP_SKIP_IF_IO_BIT_SET: n = x[b] ? 2 + b[0] : 1;
			OP_BRANCH_STATUS_BIT_SET: t = s[b];
			OP_BRANCH_STATUS_BIT_CLEAR: t = !s[b];
			OP_BRANCH_EQUAL: t = s[1];
			OP_BRANCH_NOT_EQUAL: t = !s[1];
			OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: t = s[0];
			OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: t = !s[0];
			OP_BRANCH_MINUS: t = s[2];
			OP_BRANCH_PLUS: t = !s[2];
			OP_BRANCH_SIGNED_GE: t = !(s[2] ^ s[3]);
			OP_BRANCH_SIGNED_LT: t = s[2] ^ s[3];
			OP_BRANCH_HALFCARRY_SET: t = s[5];
			OP_BRANCH_HALFCARRY_CLEAR: t = !s[5];
			OP_BRANCH_OVERFLOW_CLEAR: t = !s[3];
			OP_BRANCH_IRQ_ENABLED: t = s[7];
			OP_IO_BIT_SET: m[b] = 1'b1;
			OP_IO_BIT_CLEAR: m[b] = 1'b0;
			OP_SHIFT_LEFT_LOGICAL: {e[0], d} = {x, 1'b0};
			OP_SHIFT_RIGHT_LOGICAL: {d, e[0]} = {1'b0, x};
			OP_SHIFT_RIGHT_ARITH: {d, e[0]} = {x[7], x};
			OP_ROTATE_LEFT_CARRY: {e[0], d} = {x, s[0]};
			OP_ROTATE_RIGHT_CARRY: {d, e[0]} = {s[0], x};
			OP_STATUS_FLAG_SET: e[b] = 1'b1;
			OP_STATUS_FLAG_CLEAR: e[b] = 1'b0;
			OP_STORE_BIT_TO_TRANSFER_FLAG: e[6] = x[b];
			OP_LOAD_BIT_FROM_TRANSFER_FLAG: d[b] = s[6];
			OP_SWAP_NIBBLES: d = {x[3:0], x[7:4]};
			default: ;
		endcase
		if (op == OP_SKIP_IF_IO_BIT_SET) p = pc_e + 16'(n);
		if (op >= OP_SHIFT_LEFT_LOGICAL && op <= OP_ROTATE_RIGHT_CARRY) begin
			e[1] = d == 8'h00;
			e[2] = d[7];
			e[3] = d[7] ^ e[0];
		end
		if (t) begin
			n = 2;
			p = pc_e + {{9{o[6]}}, o} + 16'h0001;
		end
		@(posedge i_clk_sys);
		i_cmd <= '{1'b1, op, b, o, x[4:0], x, b[0]};
		@(posedge i_clk_sys);
		i_cmd.valid <= 1'b0;
		k = 0;
		do begin
			@(negedge i_clk_sys);
			k++;
		end while (o_res.done !== 1'b1 && k < 6);
		if (k == 6) begin
			fail_count++;
			complete_run();
		end
		chk("cycles", 16'(n), 16'(k));
		chk("pc", p, o_res.pc);
		chk("status", e, o_res.status);
		chk("wr_en", w, o_res.wr_en);
		if (w) chk("data", d, o_res.data);
		if (io) chk("io_wdata", m, o_io.wdata);
		pc_e = p;
	endtask
	// Status write, then a plain command to publish it, then the command under test
	task automatic run(input bsbse_op_t op, input logic [2:0] b, input logic [7:0] x,
		input logic [7:0] s);
		wr(REG_STATUS, s);
		issue(OP_NOP, 3'h0, 8'h00, s);
		issue(op, b, x, s);
	endtask
	task automatic sweep(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			for (int j = 0; j < 4; j++) run(bsbse_op_t'(i), 3'(i + j), xs[j], pats[j]);
		end
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_rst_n = 1'b0;
		i_cmd = '0;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_addr = 2'h0;
		i_reg_wdata = 8'h00;
		fail_count = 0;
		comparisons = 0;
		repeat (12) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		wr(REG_PC_LO, 8'hf0);
		wr(REG_PC_HI, 8'h01);
		pc_e = 16'h01f0;
		for (int j = 0; j < 4; j++) run(OP_SKIP_IF_IO_BIT_SET, 3'(j), {8{j[1]}}, 8'h00);
		sweep(2, 9);
		sweep(10, 17);
		sweep(18, 19);
		sweep(20, 24);
		sweep(25, 29);
		rd(REG_PC_LO);
		chk("pc_lo", pc_e[7:0], v);
		rd(REG_PC_HI);
		chk("pc_hi", pc_e[15:8], v);
		rd(REG_STATUS);
		chk("status_rd", pats[3], v);
		rd(REG_RESULT);
		chk("result_rd", {xs[3][3:0], xs[3][7:4]}, v);
		// Reset in mid-run, then the reset values checked and a shift run after release
		@(posedge i_clk_sys);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		@(negedge i_clk_sys);
		chk("ready_rst", 16'h0001, o_ready);
		chk("pc_rst", 16'h0000, o_res.pc);
		chk("status_rst", 16'h0000, o_res.status);
		pc_e = 16'h0000;
		run(OP_SHIFT_LEFT_LOGICAL, 3'h0, 8'h81, 8'h00);
		complete_run();
	end
endmodule // branch_skip_bit_shift_exec_tb
